// ---- rtig_params.svh ----
`ifndef RTIG_PARAMS_SVH
`define RTIG_PARAMS_SVH

// instruction word layout
`define RTIG_OP_W          10
`define RTIG_OP_SERIAL_RD  10'h278
`define RTIG_OP_PTR_RD     10'h051
`define RTIG_OP_CMP_WR     10'h239
`define RTIG_OP_INT_RD     10'h253

// comparator-mode select inside the adc control register
`define RTIG_CMP_MODE_BIT  3

// nibble positions
`define RTIG_HI_MSB        7
`define RTIG_HI_LSB        4
`define RTIG_LO_MSB        3
`define RTIG_LO_LSB        0
`define RTIG_PTR_MSB       2

// reset values
`define RTIG_NIB_RST       4'h0
`define RTIG_BYTE_RST      8'h00

`endif

// ---- rtig_pkg.sv ----
package rtig_pkg;
    typedef logic [3:0] rtig_nib_t;
    typedef logic [7:0] rtig_byte_t;
    typedef logic [9:0] rtig_op_t;
    typedef enum logic [2:0] {
        RTIG_OP_NONE   = 3'b000,
        RTIG_OP_SER    = 3'b001,
        RTIG_OP_PTR    = 3'b010,
        RTIG_OP_CMP    = 3'b011,
        RTIG_OP_INT    = 3'b100
    } rtig_op_kind_t;
endpackage

// ---- rtig_decode.sv ----
`timescale 1ns/100ps
`include "rtig_params.svh"

// combinational opcode classifier
module rtig_decode (
    input  wire rtig_pkg::rtig_op_t      opcode_in,
    input  wire logic                    valid_in,
    output rtig_pkg::rtig_op_kind_t      kind_out
);
    import rtig_pkg::*;

    // one-word opcodes, each matched on its full 10 bits
    always_comb begin
        kind_out = RTIG_OP_NONE;
        if (valid_in) begin
            case (opcode_in)
                `RTIG_OP_SERIAL_RD: kind_out = RTIG_OP_SER;
                `RTIG_OP_PTR_RD:    kind_out = RTIG_OP_PTR;
                `RTIG_OP_CMP_WR:    kind_out = RTIG_OP_CMP;
                `RTIG_OP_INT_RD:    kind_out = RTIG_OP_INT;
                default:            kind_out = RTIG_OP_NONE;
            endcase
        end
    end
endmodule

// ---- rtig_core.sv ----
`timescale 1ns/100ps
`include "rtig_params.svh"

// Overview of operation
// - opcode 1001111000 is the serial-read, one word, one cycle
// - serial-read loads B with shift bits 7-4, accumulator with 3-0
// - pointer-read puts 3 pointer bits in acc 2-0, acc bit 3 zero
// - opcode 1000111001 is the comparator-write, one word, one cycle
// - comparator mode: B to comparator bits 7-4, acc to bits 3-0
// - conversion mode: comparator-write changes nothing, acts as no-op
// - interrupt-control-read copies 4-bit interrupt control into acc
// - comparator mode selected by adc control register bit 3
module rtig_core (
    input  wire logic                 core_clk_in,
    input  wire logic                 rst_b_in,
    input  wire logic                 instr_valid_in,
    input  wire rtig_pkg::rtig_op_t   instr_in,
    input  wire rtig_pkg::rtig_nib_t  acc_in,
    input  wire rtig_pkg::rtig_nib_t  reg_b_in,
    input  wire rtig_pkg::rtig_byte_t serial_shift_in,
    input  wire logic [2:0]           data_pointer_bits_in,
    input  wire rtig_pkg::rtig_nib_t  int_control_reg_in,
    input  wire rtig_pkg::rtig_nib_t  adc_control_reg_in,
    output rtig_pkg::rtig_nib_t       acc_out,
    output logic                      acc_we_out,
    output rtig_pkg::rtig_nib_t       reg_b_out,
    output logic                      reg_b_we_out,
    output rtig_pkg::rtig_byte_t      cmp_reg_out,
    output logic                      cmp_we_out,
    output logic                      hit_out,
    output logic                      carry_we_out,
    output logic                      skip_out
);
    import rtig_pkg::*;

    logic          rst_meta_q;
    logic          rst_sync_q;
    rtig_op_kind_t kind;
    logic          exec_ser;
    logic          exec_ptr;
    logic          exec_cmp;
    logic          exec_int;
    logic          cmp_mode;
    rtig_nib_t     acc_d;
    logic          acc_we_d;
    rtig_nib_t     b_d;
    logic          b_we_d;
    rtig_byte_t    cmp_d;
    logic          cmp_we_d;
    logic          hit_d;

    // reset release through two stages to avoid a metastable deassert
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    rtig_decode u_decode (
        .opcode_in (instr_in),
        .valid_in  (instr_valid_in),
        .kind_out  (kind)
    );

    // one flag per instruction; keeps the hit term readable
    assign exec_ser = (kind == RTIG_OP_SER);
    assign exec_ptr = (kind == RTIG_OP_PTR);
    assign exec_cmp = (kind == RTIG_OP_CMP);
    assign exec_int = (kind == RTIG_OP_INT);
    assign hit_d    = exec_ser | exec_ptr | exec_cmp | exec_int;

    // mode bit read live; core-side register, no sync needed
    assign cmp_mode = adc_control_reg_in[`RTIG_CMP_MODE_BIT];

    // accumulator next value; unwritten cycles echo the current value
    always_comb begin
        acc_d    = acc_in;
        acc_we_d = 1'b0;
        case (kind)
            RTIG_OP_SER: begin
                // low nibble here, high nibble goes to register b
                acc_d    = serial_shift_in[`RTIG_LO_MSB:`RTIG_LO_LSB];
                acc_we_d = 1'b1;
            end
            RTIG_OP_PTR: begin
                // pointer is three bits wide, so bit 3 is forced low
                acc_d    = {1'b0, data_pointer_bits_in};
                acc_we_d = 1'b1;
            end
            RTIG_OP_INT: begin
                acc_d    = int_control_reg_in;
                acc_we_d = 1'b1;
            end
            default: begin
                // other opcodes leave the accumulator alone
                acc_d    = acc_in;
                acc_we_d = 1'b0;
            end
        endcase
    end

    // register b next value; only the serial read writes it
    always_comb begin
        b_d    = reg_b_in;
        b_we_d = 1'b0;
        case (kind)
            RTIG_OP_SER: begin
                // high nibble of the shift register
                b_d    = serial_shift_in[`RTIG_HI_MSB:`RTIG_HI_LSB];
                b_we_d = 1'b1;
            end
            default: begin
                b_d    = reg_b_in;
                b_we_d = 1'b0;
            end
        endcase
    end

    // comparator next value; conversion mode turns the write into a no-op
    always_comb begin
        cmp_d    = cmp_reg_out;
        cmp_we_d = 1'b0;
        case (kind)
            RTIG_OP_CMP: begin
                if (cmp_mode) begin
                    cmp_d    = {reg_b_in, acc_in};
                    cmp_we_d = 1'b1;
                end else begin
                    // conversion mode leaves every register alone
                    cmp_d    = cmp_reg_out;
                    cmp_we_d = 1'b0;
                end
            end
            default: begin
                // idle cycles re-load the held value
                cmp_d    = cmp_reg_out;
                cmp_we_d = 1'b0;
            end
        endcase
    end

    // accumulator result, echoes acc_in when not written
    always_ff @(posedge core_clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            acc_out <= `RTIG_NIB_RST;
        end else begin
            acc_out <= acc_d;
        end
    end

    // accumulator strobe, one cycle; the sequencer commits on it
    always_ff @(posedge core_clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            acc_we_out <= 1'b0;
        end else begin
            acc_we_out <= acc_we_d;
        end
    end

    // register b result, echoes reg_b_in when not written
    always_ff @(posedge core_clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            reg_b_out <= `RTIG_NIB_RST;
        end else begin
            reg_b_out <= b_d;
        end
    end

    // register b strobe, one cycle
    always_ff @(posedge core_clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            reg_b_we_out <= 1'b0;
        end else begin
            reg_b_we_out <= b_we_d;
        end
    end

    // comparator register holds its value unless written in compare mode
    always_ff @(posedge core_clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            cmp_reg_out <= `RTIG_BYTE_RST;
        end else begin
            cmp_reg_out <= cmp_d;
        end
    end

    // comparator strobe, low for the conversion-mode no-op
    always_ff @(posedge core_clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            cmp_we_out <= 1'b0;
        end else begin
            cmp_we_out <= cmp_we_d;
        end
    end

    // handled flag toward the sequencer, no-op case included
    always_ff @(posedge core_clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            hit_out <= 1'b0;
        end else begin
            hit_out <= hit_d;
        end
    end

    // carry is never touched by this group
    always_ff @(posedge core_clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            carry_we_out <= 1'b0;
        end else begin
            carry_we_out <= 1'b0;
        end
    end

    // no skip condition in this group
    always_ff @(posedge core_clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            skip_out <= 1'b0;
        end else begin
            skip_out <= 1'b0;
        end
    end
endmodule

// ---- rtig_sva.sv ----
`timescale 1ns/100ps
module rtig_sva (
    input wire logic       core_clk_in,
    input wire logic       rst_b_in,
    input wire logic       instr_valid_in,
    input wire logic [9:0] instr_in,
    input wire logic [3:0] acc_in,
    input wire logic [3:0] reg_b_in,
    input wire logic [7:0] serial_shift_in,
    input wire logic [2:0] data_pointer_bits_in,
    input wire logic [3:0] int_control_reg_in,
    input wire logic [3:0] adc_control_reg_in,
    input wire logic [3:0] acc_out,
    input wire logic       acc_we_out,
    input wire logic [3:0] reg_b_out,
    input wire logic       reg_b_we_out,
    input wire logic [7:0] cmp_reg_out,
    input wire logic       cmp_we_out,
    input wire logic       hit_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);
    // opcode matches, mode taken at the same edge
    wire ser = instr_valid_in && instr_in == 10'h278;
    wire ptr = instr_valid_in && instr_in == 10'h051;
    wire cmp = instr_valid_in && instr_in == 10'h239;
    wire irq = instr_valid_in && instr_in == 10'h253;
    wire md = adc_control_reg_in[3];
    a_hit_match: assert property (
        hit_out == $past(ser || ptr || cmp || irq)) else $error("hit");
    a_b_strobe: assert property (
        reg_b_we_out == $past(ser)) else $error("b we");
    a_acc_strobe: assert property (
        acc_we_out == $past(ser || ptr || irq)) else $error("acc we");
    a_cmp_write: assert property (
        cmp && md |=> cmp_we_out) else $error("cmp we");
    a_cmp_cause: assert property (
        cmp_we_out |-> $past(cmp && md)) else $error("cmp cause");
    a_cmp_nop: assert property (
        cmp && !md |=> !cmp_we_out && !acc_we_out) else $error("nop");
    a_cmp_hold: assert property (
        !cmp_we_out |-> $stable(cmp_reg_out)) else $error("hold");
    a_ptr_no_b: assert property (
        ptr |=> !reg_b_we_out) else $error("ptr b");
    // data paths, one cycle after the opcode is taken
    a_ser_data: assert property (
        ser |=> {reg_b_out, acc_out} == $past(serial_shift_in))
        else $error("ser data");
    a_ptr_data: assert property (
        ptr |=> acc_out == {1'b0, $past(data_pointer_bits_in)})
        else $error("ptr data");
    a_int_data: assert property (
        irq |=> acc_out == $past(int_control_reg_in)) else $error("int data");
    a_cmp_data: assert property (
        cmp && md |=> cmp_reg_out == {$past(reg_b_in), $past(acc_in)})
        else $error("cmp data");
endmodule
bind rtig_core rtig_sva chk (
    .core_clk_in          (core_clk_in),
    .rst_b_in             (rst_b_in),
    .instr_valid_in       (instr_valid_in),
    .instr_in             (instr_in),
    .acc_in               (acc_in),
    .reg_b_in             (reg_b_in),
    .serial_shift_in      (serial_shift_in),
    .data_pointer_bits_in (data_pointer_bits_in),
    .int_control_reg_in   (int_control_reg_in),
    .adc_control_reg_in   (adc_control_reg_in),
    .acc_out              (acc_out),
    .acc_we_out           (acc_we_out),
    .reg_b_out            (reg_b_out),
    .reg_b_we_out         (reg_b_we_out),
    .cmp_reg_out          (cmp_reg_out),
    .cmp_we_out           (cmp_we_out),
    .hit_out              (hit_out)
);

// ---- tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
    logic       core_clk_in = 1'h0, rst_b_in = 1'h0, instr_valid_in = 1'h0;
    logic [9:0] instr_in = 10'h000;
    logic [7:0] serial_shift_in = 8'hA5;
    logic [2:0] data_pointer_bits_in = 3'h7;
    logic [3:0] acc_in = 4'hF, reg_b_in = 4'h3, int_control_reg_in = 4'h9;
    logic [3:0] adc_control_reg_in = 4'h8, acc_out, reg_b_out;
    logic [7:0] cmp_reg_out;
    logic       acc_we_out, reg_b_we_out, cmp_we_out, hit_out;
    logic       carry_we_out, skip_out;
    int         failures = 0, n_tests = 0;
    rtig_core dut (
        .core_clk_in          (core_clk_in),
        .rst_b_in             (rst_b_in),
        .instr_valid_in       (instr_valid_in),
        .instr_in             (instr_in),
        .acc_in               (acc_in),
        .reg_b_in             (reg_b_in),
        .serial_shift_in      (serial_shift_in),
        .data_pointer_bits_in (data_pointer_bits_in),
        .int_control_reg_in   (int_control_reg_in),
        .adc_control_reg_in   (adc_control_reg_in),
        .acc_out              (acc_out),
        .acc_we_out           (acc_we_out),
        .reg_b_out            (reg_b_out),
        .reg_b_we_out         (reg_b_we_out),
        .cmp_reg_out          (cmp_reg_out),
        .cmp_we_out           (cmp_we_out),
        .hit_out              (hit_out),
        .carry_we_out         (carry_we_out),
        .skip_out             (skip_out)
    );
    // 4 ns clock
    initial forever #2 core_clk_in = ~core_clk_in;
    task chk(input logic [11:0] s, e, input string n);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask
    // strobe stays up, so the next edge repeats the opcode harmlessly
    task go(input logic [9:0] op);
        instr_in <= op;
        instr_valid_in <= 1'h1;
        @(posedge core_clk_in);
        #1;
    endtask
    task t_load;
        @(posedge core_clk_in);
        go(10'h278);
        chk(12'({reg_b_out, acc_out, reg_b_we_out}), 12'h14B, "ser");
        chk(12'({acc_we_out, hit_out}), 12'h003, "ser we");
        @(posedge core_clk_in);
        go(10'h051);
        chk(12'({acc_out, reg_b_we_out}), 12'h00E, "ptr");
        chk(12'({acc_we_out, hit_out}), 12'h003, "ptr we");
        @(posedge core_clk_in);
        go(10'h253);
        chk(12'({acc_out, carry_we_out, skip_out}), 12'h024,
            "int");
        chk(12'({acc_we_out, reg_b_we_out}), 12'h002, "int we");
        $display("load test done");
    endtask
    task t_cmp;
        @(posedge core_clk_in);
        go(10'h239);
        chk(12'({cmp_reg_out, cmp_we_out}), 12'h07F, "cmp");
        @(posedge core_clk_in);
        adc_control_reg_in <= 4'h7;
        reg_b_in <= 4'h5;
        go(10'h239);
        chk(12'({cmp_reg_out, cmp_we_out, hit_out}), 12'h0FD,
            "nop");
        chk(12'({acc_we_out, reg_b_we_out}), 12'h000, "nop we");
        $display("cmp test done");
    endtask
    // near-miss opcode and a dropped valid are both ignored
    task t_refuse;
        @(posedge core_clk_in);
        go(10'h279);
        chk(12'({hit_out, acc_we_out, cmp_we_out}), 12'h000, "odd");
        @(posedge core_clk_in);
        instr_in       <= 10'h278;
        instr_valid_in <= 1'h0;
        @(posedge core_clk_in);
        #1;
        chk(12'({hit_out, reg_b_we_out}), 12'h000, "idle");
        $display("refuse test done");
    endtask
    task print_verdict;
        $display("%0d checks %0d failed", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // reset, then the scenarios
    initial begin
        repeat (10) @(posedge core_clk_in);
        rst_b_in <= 1'h1;
        repeat (3) @(posedge core_clk_in);
        t_load;
        t_cmp;
        t_refuse;
        print_verdict;
    end
endmodule
